/* rtl/dam_ports.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// RQ1 - dual-access block serves two accesses per cycle, one per half-cycle
// RQ2 - single-access block serves at most one access per cycle
// RQ3 - fetch bus returns 32-bit words; fetch takes both halves of dual block
// RQ4 - single data read uses read bus one, second half-cycle
// RQ5 - dual read: first on bus one first half, second on bus two second half
// RQ6 - coefficient read uses coefficient bus, 16 bits, second half-cycle
// RQ7 - single data write uses write bus one, first half-cycle
// RQ8 - dual write: first on bus two second half, second on bus one first half
// RQ9 - long read: address on bus one, halves on buses one and two, second half
// RQ10 - long write: address on bus one, halves on write buses, both halves
// RQ11 - read buses carry 16 bits; only bus one reaches I/O space
// RQ12 - write buses carry 16 bits; only bus one reaches I/O space
// RQ13 - coefficient in same dual block as first dual read costs one cycle
// RQ14 - three-cycle access: request, array access, data transfer
// RQ15 - data accesses beat program fetches, which beat DMA
// RQ16 - write losing to a dual read is buffered and done a cycle later; if both dual writes lose, only bus one's is buffered, bus two stalls
// RQ17 - reads of a pending write location take the write data instead
// RQ18 - request losing its slot stalls until a slot frees
module dam_ports import dam_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_rd1_req,
  input wire logic [15:0] i_rd1_addr,
  input wire logic i_rd1_io,
  input wire logic i_rd_long,
  input wire logic i_rd2_req,
  input wire logic [15:0] i_rd2_addr,
  input wire logic i_coef_req,
  input wire logic [15:0] i_coef_addr,
  input wire logic i_wr1_req,
  input wire logic [15:0] i_wr1_addr,
  input wire logic [15:0] i_wr1_data,
  input wire logic i_wr1_io,
  input wire logic i_wr_long,
  input wire logic i_wr2_req,
  input wire logic [15:0] i_wr2_addr,
  input wire logic [15:0] i_wr2_data,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  input wire logic i_dma_req,
  input wire logic i_dma_we,
  input wire logic [15:0] i_dma_addr,
  input wire logic [15:0] i_dma_wdata,
  input wire logic [15:0] i_io_rdata,
  output logic o_data_stall,
  output logic o_fetch_stall,
  output logic o_dma_stall,
  output logic [15:0] o_read_bus_one,
  output logic o_read_bus_one_vld,
  output logic [15:0] o_read_bus_two,
  output logic o_read_bus_two_vld,
  output logic [15:0] o_coef_read_bus,
  output logic o_coef_vld,
  output logic [31:0] o_fetch_bus,
  output logic o_fetch_vld,
  output logic [15:0] o_dma_rdata,
  output logic o_dma_vld,
  output logic o_io_rd,
  output logic [15:0] o_io_rd_addr,
  output logic o_io_wr,
  output logic [15:0] o_io_wr_addr,
  output logic [15:0] o_io_wdata,
  output logic o_wr_pend
);
  ////////////////////////////////////////////////////////////////////////////
  // access-stage registers and images
  logic s1_rd1_v, s1_rd1_io, s1_rd_long, s1_rd2_v, s1_coef_v;
  logic s1_wr1_v, s1_wr1_io, s1_wr_long, s1_wr2_v;
  logic s1_fetch_v, s1_dma_v, s1_dma_we;
  logic [15:0] s1_rd1_a, s1_rd2_a, s1_coef_a, s1_wr1_a, s1_wr2_a;
  logic [15:0] s1_wr1_d, s1_wr2_d, s1_fetch_a, s1_dma_a, s1_dma_d;
  logic pend_v, pend_blk, pend_lo;
  dam_paddr_type pend_pa;
  dam_half_type pend_need;
  logic [31:0] pend_wd;
  logic [1:0] pend_we;
  logic acc_v [DAM_NACC];
  logic acc_blk [DAM_NACC];
  logic acc_lo [DAM_NACC];
  logic acc_onb [DAM_NACC];
  dam_half_type acc_need [DAM_NACC];
  dam_paddr_type acc_pa [DAM_NACC];
  logic [31:0] acc_wd [DAM_NACC];
  logic [1:0] acc_we [DAM_NACC];
  logic [31:0] rd_a [DAM_NBLK];
  logic [31:0] rd_b [DAM_NBLK];
  logic [DAM_NACC-1:0] gnt_all [DAM_NBLK];
  logic [DAM_NACC-1:0] gnt;
  logic [31:0] rdpair [DAM_NACC];
  dam_half_type rd1_need, wr1_need, dma_need;
  logic coef_clash, pend_free, mv1, mv2;
  logic srv_rd1, srv_wr1, srv_wr2;
  logic rd1_left, rd2_left, coef_left, wr1_left, wr2_left;
  logic [31:0] wr1_wd;
  logic [1:0] wr1_we;
  function automatic logic [1:0] word_we(input logic lo);
    return lo ? DAM_WE_ODD : DAM_WE_EVEN;
  endfunction
  function automatic logic [15:0] pick(input logic [31:0] pair, input logic lo);
    return lo ? pair[15:0] : pair[31:16];
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] base, input logic hit,
                                        input logic [1:0] we, input logic [31:0] wd);
    logic [31:0] r;
    r = base;
    if (hit && we[1]) r[31:16] = wd[31:16];
    if (hit && we[0]) r[15:0] = wd[15:0];
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // half-cycle needs per access type
  assign rd1_need = (s1_rd2_v && !s1_rd_long) ? DAM_HALF_ONE : DAM_HALF_TWO; // [RQ4] [RQ5] [RQ9]
  assign wr1_need = s1_wr_long ? DAM_HALF_BOTH : DAM_HALF_ONE; // [RQ7] [RQ8] [RQ10]
  assign wr1_wd = s1_wr_long ? {s1_wr1_d, s1_wr2_d} : {s1_wr1_d, s1_wr1_d}; // [RQ10]
  assign wr1_we = s1_wr_long ? DAM_WE_PAIR : word_we(s1_wr1_a[0]);
  assign dma_need = s1_dma_we ? DAM_HALF_ONE : DAM_HALF_TWO;
  // coefficient waits a cycle behind a first dual read in its dual block
  assign coef_clash = s1_rd1_v && !s1_rd1_io && s1_rd2_v && !s1_rd_long && // [RQ13]
                      s1_coef_a[DAM_BLK_BIT] == s1_rd1_a[DAM_BLK_BIT] &&
                      s1_coef_a[DAM_BLK_BIT] == 1'(DAM_BLK_DUAL);
  // images, index order is priority order: data, then fetch, then dma
  assign acc_v = '{pend_v,
                   s1_rd1_v && !s1_rd1_io, // [RQ11]
                   s1_rd2_v,
                   s1_coef_v && !coef_clash,
                   s1_wr1_v && !s1_wr1_io, // [RQ12]
                   s1_wr2_v,
                   s1_fetch_v, // [RQ15]
                   s1_dma_v};
  assign acc_need = '{pend_need, rd1_need,
                      DAM_HALF_TWO, // [RQ5]
                      DAM_HALF_TWO, // [RQ6]
                      wr1_need,
                      DAM_HALF_TWO, // [RQ8]
                      DAM_HALF_BOTH, // [RQ3]
                      dma_need};
  assign acc_blk = '{pend_blk, s1_rd1_a[DAM_BLK_BIT], s1_rd2_a[DAM_BLK_BIT],
                     s1_coef_a[DAM_BLK_BIT], s1_wr1_a[DAM_BLK_BIT], s1_wr2_a[DAM_BLK_BIT],
                     s1_fetch_a[DAM_BLK_BIT], s1_dma_a[DAM_BLK_BIT]};
  assign acc_pa = '{pend_pa, s1_rd1_a[DAM_BANK_AW-1:1], s1_rd2_a[DAM_BANK_AW-1:1],
                    s1_coef_a[DAM_BANK_AW-1:1], s1_wr1_a[DAM_BANK_AW-1:1],
                    s1_wr2_a[DAM_BANK_AW-1:1], s1_fetch_a[DAM_BANK_AW-1:1],
                    s1_dma_a[DAM_BANK_AW-1:1]};
  assign acc_lo = '{pend_lo, s1_rd1_a[0], s1_rd2_a[0], s1_coef_a[0], s1_wr1_a[0],
                    s1_wr2_a[0], s1_fetch_a[0], s1_dma_a[0]};
  assign acc_wd = '{pend_wd, DAM_PAIR_RST, DAM_PAIR_RST, DAM_PAIR_RST, wr1_wd,
                    {s1_wr2_d, s1_wr2_d}, DAM_PAIR_RST, {s1_dma_d, s1_dma_d}};
  assign acc_we = '{pend_we, DAM_WE_NONE, DAM_WE_NONE, DAM_WE_NONE, wr1_we,
                    word_we(s1_wr2_a[0]), DAM_WE_NONE,
                    s1_dma_we ? word_we(s1_dma_a[0]) : DAM_WE_NONE};
  ////////////////////////////////////////////////////////////////////////////
  // per-block slot allocation and arrays
  for (genvar b = 0; b < DAM_NBLK; b++) begin : g_blk
    localparam logic BLK_ID = 1'(b);
    localparam logic IS_SINGLE = (b == DAM_BLK_SINGLE);
    dam_half_type used, eff;
    logic [DAM_NACC-1:0] gnt_b;
    logic [1:0] we_a, we_b;
    dam_paddr_type pa_a, pa_b;
    logic [31:0] wd_a, wd_b;
    // first free fit in priority order; a loser simply stays pending
    always_comb begin
      used = DAM_HALF_NONE;
      eff = DAM_HALF_NONE;
      gnt_b = '0;
      we_a = DAM_WE_NONE;
      we_b = DAM_WE_NONE;
      pa_a = '0;
      pa_b = '0;
      wd_a = DAM_PAIR_RST;
      wd_b = DAM_PAIR_RST;
      for (int k = 0; k < DAM_NACC; k++) begin
        eff = IS_SINGLE ? DAM_HALF_BOTH : acc_need[k]; // [RQ2]
        if (acc_v[k] && acc_blk[k] == BLK_ID && (used & eff) == DAM_HALF_NONE) begin // [RQ15] [RQ18]
          gnt_b[k] = 1'b1;
          used = used | eff;
          if (eff == DAM_HALF_TWO) begin // [RQ1]
            we_b = acc_we[k];
            pa_b = acc_pa[k];
            wd_b = acc_wd[k];
          end else begin
            we_a = acc_we[k];
            pa_a = acc_pa[k];
            wd_a = acc_wd[k];
          end
        end
      end
    end
    assign gnt_all[b] = gnt_b;
    dam_bank u_bank (
      .i_core_clk(i_core_clk),
      .i_we_a(we_a),
      .i_pa_a(pa_a),
      .i_wd_a(wd_a),
      .i_we_b(we_b),
      .i_pa_b(pa_b),
      .i_wd_b(wd_b),
      .o_rd_a(rd_a[b]),
      .o_rd_b(rd_b[b])
    );
  end
  ////////////////////////////////////////////////////////////////////////////
  // grants, read data with write forwarding
  always_comb begin
    for (int k = 0; k < DAM_NACC; k++) begin
      gnt[k] = gnt_all[acc_blk[k]][k];
      acc_onb[k] = acc_need[k] == DAM_HALF_TWO && acc_blk[k] != 1'(DAM_BLK_SINGLE);
      rdpair[k] = acc_onb[k] ? rd_b[acc_blk[k]] : rd_a[acc_blk[k]];
      // older writes first so the newest data lands last
      for (int w = 0; w < DAM_NACC; w++) begin
        rdpair[k] = merge(rdpair[k], acc_v[w] && acc_blk[w] == acc_blk[k] && // [RQ17]
                          acc_pa[w] == acc_pa[k], acc_we[w], acc_wd[w]);
      end
    end
  end
  // a lost write parks in the single buffer so the reads go on
  assign pend_free = !pend_v || gnt[DAM_ACC_PEND];
  assign mv1 = acc_v[DAM_ACC_WR1] && !gnt[DAM_ACC_WR1] && pend_free; // [RQ16]
  assign mv2 = acc_v[DAM_ACC_WR2] && !gnt[DAM_ACC_WR2] && pend_free && !mv1; // [RQ16]
  // i/o accesses bypass the arrays and are served at once
  assign srv_rd1 = gnt[DAM_ACC_RD1] || (s1_rd1_v && s1_rd1_io); // [RQ11]
  assign srv_wr1 = gnt[DAM_ACC_WR1] || mv1 || (s1_wr1_v && s1_wr1_io); // [RQ12]
  assign srv_wr2 = gnt[DAM_ACC_WR2] || mv2;
  assign rd1_left = s1_rd1_v && !srv_rd1;
  assign rd2_left = s1_rd2_v && !gnt[DAM_ACC_RD2];
  assign coef_left = s1_coef_v && !gnt[DAM_ACC_COEF]; // [RQ13]
  assign wr1_left = s1_wr1_v && !srv_wr1;
  assign wr2_left = s1_wr2_v && !srv_wr2;
  assign o_data_stall = rd1_left || rd2_left || coef_left || wr1_left || wr2_left; // [RQ18]
  assign o_fetch_stall = s1_fetch_v && !gnt[DAM_ACC_FETCH]; // [RQ18]
  assign o_dma_stall = s1_dma_v && !gnt[DAM_ACC_DMA]; // [RQ18]
  assign o_io_rd = s1_rd1_v && s1_rd1_io;
  assign o_io_rd_addr = s1_rd1_a;
  assign o_io_wr = s1_wr1_v && s1_wr1_io;
  assign o_io_wr_addr = s1_wr1_a;
  assign o_io_wdata = s1_wr1_d;
  assign o_wr_pend = pend_v;
  ////////////////////////////////////////////////////////////////////////////
  // request stage: take new data requests unless some are still waiting
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {s1_rd1_v, s1_rd1_io, s1_rd_long, s1_rd2_v, s1_coef_v} <= '0;
      {s1_wr1_v, s1_wr1_io, s1_wr_long, s1_wr2_v} <= '0;
      {s1_rd1_a, s1_rd2_a, s1_coef_a, s1_wr1_a, s1_wr2_a} <= '0;
      {s1_wr1_d, s1_wr2_d} <= '0;
    end else if (o_data_stall) begin
      s1_rd1_v <= rd1_left;
      s1_rd2_v <= rd2_left;
      s1_coef_v <= coef_left;
      s1_wr1_v <= wr1_left;
      s1_wr2_v <= wr2_left;
    end else begin
      s1_rd1_v <= i_rd1_req; // [RQ14]
      s1_rd1_io <= i_rd1_io;
      s1_rd_long <= i_rd_long;
      s1_rd2_v <= i_rd2_req && !i_rd_long;
      s1_coef_v <= i_coef_req;
      s1_wr1_v <= i_wr1_req;
      s1_wr1_io <= i_wr1_io;
      s1_wr_long <= i_wr_long;
      s1_wr2_v <= i_wr2_req && !i_wr_long;
      s1_rd1_a <= i_rd1_addr;
      s1_rd2_a <= i_rd2_addr;
      s1_coef_a <= i_coef_addr;
      s1_wr1_a <= i_wr1_addr;
      s1_wr2_a <= i_wr2_addr;
      s1_wr1_d <= i_wr1_data;
      s1_wr2_d <= i_wr2_data;
    end
  end
  // fetch and dma request stages stall on their own
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {s1_fetch_v, s1_dma_v, s1_dma_we} <= '0;
      {s1_fetch_a, s1_dma_a, s1_dma_d} <= '0;
    end else begin
      if (!o_fetch_stall) begin
        s1_fetch_v <= i_fetch_req;
        s1_fetch_a <= i_fetch_addr;
      end
      if (!o_dma_stall) begin
        s1_dma_v <= i_dma_req;
        s1_dma_we <= i_dma_we;
        s1_dma_a <= i_dma_addr;
        s1_dma_d <= i_dma_wdata;
      end
    end
  end
  // write-pending buffer, retried at top priority next cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {pend_v, pend_blk, pend_lo, pend_pa, pend_need} <= '0;
      pend_wd <= DAM_PAIR_RST;
      pend_we <= DAM_WE_NONE;
    end else begin
      pend_v <= mv1 || mv2 || (pend_v && !gnt[DAM_ACC_PEND]); // [RQ16]
      if (mv1 || mv2) begin
        pend_blk <= mv1 ? acc_blk[DAM_ACC_WR1] : acc_blk[DAM_ACC_WR2];
        pend_lo <= mv1 ? acc_lo[DAM_ACC_WR1] : acc_lo[DAM_ACC_WR2];
        pend_pa <= mv1 ? acc_pa[DAM_ACC_WR1] : acc_pa[DAM_ACC_WR2];
        pend_need <= mv1 ? acc_need[DAM_ACC_WR1] : acc_need[DAM_ACC_WR2];
        pend_wd <= mv1 ? acc_wd[DAM_ACC_WR1] : acc_wd[DAM_ACC_WR2];
        pend_we <= mv1 ? acc_we[DAM_ACC_WR1] : acc_we[DAM_ACC_WR2];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // data transfer stage; data holds its last value between transfers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_read_bus_one, o_read_bus_two, o_coef_read_bus, o_dma_rdata} <= '0;
      o_fetch_bus <= DAM_PAIR_RST;
      {o_read_bus_one_vld, o_read_bus_two_vld, o_coef_vld} <= '0;
      {o_fetch_vld, o_dma_vld} <= '0;
    end else begin
      o_read_bus_one_vld <= srv_rd1; // [RQ14]
      o_read_bus_two_vld <= gnt[DAM_ACC_RD2] || (gnt[DAM_ACC_RD1] && s1_rd_long); // [RQ9]
      o_coef_vld <= gnt[DAM_ACC_COEF];
      o_fetch_vld <= gnt[DAM_ACC_FETCH];
      o_dma_vld <= gnt[DAM_ACC_DMA] && !s1_dma_we;
      if (srv_rd1) begin
        o_read_bus_one <= s1_rd1_io ? i_io_rdata : // [RQ11]
                          s1_rd_long ? rdpair[DAM_ACC_RD1][31:16] : // [RQ9]
                          pick(rdpair[DAM_ACC_RD1], acc_lo[DAM_ACC_RD1]);
      end
      if (gnt[DAM_ACC_RD1] && s1_rd_long) o_read_bus_two <= rdpair[DAM_ACC_RD1][15:0]; // [RQ9]
      if (gnt[DAM_ACC_RD2]) o_read_bus_two <= pick(rdpair[DAM_ACC_RD2], acc_lo[DAM_ACC_RD2]);
      if (gnt[DAM_ACC_COEF]) o_coef_read_bus <= pick(rdpair[DAM_ACC_COEF], acc_lo[DAM_ACC_COEF]); // [RQ6]
      if (gnt[DAM_ACC_FETCH]) o_fetch_bus <= rdpair[DAM_ACC_FETCH]; // [RQ3]
      if (gnt[DAM_ACC_DMA]) o_dma_rdata <= pick(rdpair[DAM_ACC_DMA], acc_lo[DAM_ACC_DMA]);
    end
  end
endmodule
`default_nettype wire

/* rtl/dam_pkg.sv */
package dam_pkg;
  // data and fetch widths
  localparam int DAM_DW = 16;
  localparam int DAM_FW = 32;
  localparam int DAM_AW = 16;
  // each block holds 2**DAM_BANK_AW words, stored as even/odd pairs
  localparam int DAM_BANK_AW = 8;
  localparam int DAM_PAIR_AW = DAM_BANK_AW - 1;
  localparam int DAM_BLK_BIT = 8;
  localparam int DAM_NBLK = 2;
  localparam int DAM_BLK_DUAL = 0;
  localparam int DAM_BLK_SINGLE = 1;
  // access slots, listed in falling priority
  localparam int DAM_NACC = 8;
  localparam int DAM_ACC_PEND = 0;
  localparam int DAM_ACC_RD1 = 1;
  localparam int DAM_ACC_RD2 = 2;
  localparam int DAM_ACC_COEF = 3;
  localparam int DAM_ACC_WR1 = 4;
  localparam int DAM_ACC_WR2 = 5;
  localparam int DAM_ACC_FETCH = 6;
  localparam int DAM_ACC_DMA = 7;
  // half-cycle masks: bit 0 first half, bit 1 second half
  localparam logic [1:0] DAM_HALF_NONE = 2'h0;
  localparam logic [1:0] DAM_HALF_ONE = 2'h1;
  localparam logic [1:0] DAM_HALF_TWO = 2'h2;
  localparam logic [1:0] DAM_HALF_BOTH = 2'h3;
  // word enables inside a pair
  localparam logic [1:0] DAM_WE_NONE = 2'h0;
  localparam logic [1:0] DAM_WE_EVEN = 2'h2;
  localparam logic [1:0] DAM_WE_ODD = 2'h1;
  localparam logic [1:0] DAM_WE_PAIR = 2'h3;
  // reset values
  localparam logic [15:0] DAM_WORD_RST = 16'h0000;
  localparam logic [31:0] DAM_PAIR_RST = 32'h0000_0000;
  // request, array access, data transfer
  localparam int DAM_PIPE_CYCLES = 3;
  typedef logic [DAM_PAIR_AW-1:0] dam_paddr_type;
  typedef logic [1:0] dam_half_type;
endpackage

/* rtl/dam_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module dam_bank import dam_pkg::*; (
  input wire logic i_core_clk,
  input wire logic [1:0] i_we_a,
  input wire dam_paddr_type i_pa_a,
  input wire logic [31:0] i_wd_a,
  input wire logic [1:0] i_we_b,
  input wire dam_paddr_type i_pa_b,
  input wire logic [31:0] i_wd_b,
  output logic [31:0] o_rd_a,
  output logic [31:0] o_rd_b
);
  logic [15:0] mem [2**DAM_BANK_AW];

  // first-half port writes before second-half port, so b wins a tie
  always_ff @(posedge i_core_clk) begin
    if (i_we_a[1]) mem[{i_pa_a, 1'b0}] <= i_wd_a[31:16];
    if (i_we_a[0]) mem[{i_pa_a, 1'b1}] <= i_wd_a[15:0];
    if (i_we_b[1]) mem[{i_pa_b, 1'b0}] <= i_wd_b[31:16];
    if (i_we_b[0]) mem[{i_pa_b, 1'b1}] <= i_wd_b[15:0];
  end

  // array read is combinational; the caller registers it
  assign o_rd_a = {mem[{i_pa_a, 1'b0}], mem[{i_pa_a, 1'b1}]};
  assign o_rd_b = {mem[{i_pa_b, 1'b0}], mem[{i_pa_b, 1'b1}]};
endmodule
`default_nettype wire

/* tb/dam_io_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dam_io_model #(
  parameter logic [15:0] KEY = 16'hA5A5
) (
  input wire logic i_core_clk,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_addr,
  output logic [15:0] o_rdata
);
  logic [15:0] churn = 16'h0000;
  // free-running pattern so a stale bus never passes for an answer
  always @(posedge i_core_clk) begin
    churn <= churn + 16'h1357;
  end
  // io space answers only while the read strobe stands
  assign o_rdata = i_io_rd ? (i_io_addr ^ KEY) : ~churn;
endmodule
`default_nettype wire

/* tb/dam_ports_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dam_ports_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_rd1_req,
  input wire logic [15:0] i_rd1_addr,
  input wire logic i_rd1_io,
  input wire logic i_rd_long,
  input wire logic i_rd2_req,
  input wire logic [15:0] i_rd2_addr,
  input wire logic i_coef_req,
  input wire logic [15:0] i_coef_addr,
  input wire logic i_wr1_req,
  input wire logic [15:0] i_wr1_addr,
  input wire logic i_wr1_io,
  input wire logic i_wr_long,
  input wire logic i_wr2_req,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  input wire logic o_data_stall,
  input wire logic o_fetch_stall,
  input wire logic o_read_bus_one_vld,
  input wire logic o_coef_vld,
  input wire logic o_fetch_vld,
  input wire logic o_io_rd,
  input wire logic [15:0] o_io_rd_addr,
  input wire logic o_wr_pend
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////
  // request shapes; bit 8 of an address picks the block
  wire rr = i_rd1_req && i_rd2_req && !i_rd_long && !i_rd1_io;
  wire rr0 = rr && !i_rd1_addr[8] && !i_rd2_addr[8];
  wire nowr = !i_wr1_req && !i_wr2_req;
  wire wr0 = i_wr1_req && !i_wr1_io && !i_wr_long && !i_wr2_req && !i_wr1_addr[8];
  ////////////////////////////////////////////////////////////////
  rd_latency_a: assert property (i_rd1_req && !i_rd1_io && !o_data_stall ##1 !o_data_stall |=> o_read_bus_one_vld)
    else $error("read bus one answer late");
  io_read_a: assert property (i_rd1_req && i_rd1_io && !o_data_stall |=> o_io_rd && o_io_rd_addr == $past(i_rd1_addr))
    else $error("io read strobe missing");
  single_blk_a: assert property (rr && i_rd1_addr[8] && i_rd2_addr[8] && !o_data_stall |=> o_data_stall)
    else $error("two reads served in one cycle");
  dual_two_a: assert property (rr0 && nowr && !i_coef_req && !o_data_stall ##1 !o_wr_pend |-> !o_data_stall)
    else $error("dual block stalled two reads");
  coef_delay_a: assert property (rr0 && nowr && i_coef_req && !i_coef_addr[8] && !o_data_stall ##1 !o_wr_pend
    |-> o_data_stall ##1 !o_data_stall ##1 o_coef_vld) else $error("coef clash cost wrong");
  wr_pend_a: assert property (rr0 && wr0 && !i_coef_req && !o_data_stall ##1 !o_wr_pend
    |-> !o_data_stall ##1 o_wr_pend) else $error("losing write not held");
  fetch_prio_a: assert property (i_rd1_req && !i_rd1_io && i_rd1_addr[8] && i_fetch_req && i_fetch_addr[8]
    && !o_data_stall && !o_fetch_stall |=> o_fetch_stall) else $error("fetch beat data");
  fetch_lat_a: assert property (i_fetch_req && !o_fetch_stall ##1 !o_fetch_stall |=> o_fetch_vld)
    else $error("fetch answer late");
  // main scenarios reached
  cover property (o_wr_pend);
  cover property (o_fetch_stall);
  cover property (o_io_rd);
endmodule
bind dam_ports dam_ports_chk u_dam_ports_chk (.*);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] IO_KEY = 16'hA5A5;
  logic i_core_clk, i_rst_n, i_rd1_req, i_rd1_io, i_rd_long, i_rd2_req, i_coef_req, i_wr1_req, i_wr1_io;
  logic i_wr_long, i_wr2_req, i_fetch_req, i_dma_req, i_dma_we;
  logic [15:0] i_rd1_addr, i_rd2_addr, i_coef_addr, i_wr1_addr, i_wr1_data, i_wr2_addr, i_wr2_data;
  logic [15:0] i_fetch_addr, i_dma_addr, i_dma_wdata, i_io_rdata;
  logic o_data_stall, o_fetch_stall, o_dma_stall, o_read_bus_one_vld, o_read_bus_two_vld, o_coef_vld;
  logic o_fetch_vld, o_dma_vld, o_io_rd, o_io_wr, o_wr_pend;
  logic [15:0] o_read_bus_one, o_read_bus_two, o_coef_read_bus, o_dma_rdata, o_io_rd_addr, o_io_wr_addr, o_io_wdata;
  logic [31:0] o_fetch_bus, rf, iow;
  logic [15:0] r1, r2, rc, rdm;
  logic [2:0] seen;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;

  dam_ports u_dam_ports (.*);
  dam_io_model #(.KEY(IO_KEY)) u_dam_io_model (.i_core_clk(i_core_clk), .i_io_rd(o_io_rd),
    .i_io_addr(o_io_rd_addr), .o_rdata(i_io_rdata));
  ////////////////////////////////////////////////////////////////
  always #2 i_core_clk = ~i_core_clk;
  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end
  // answers stand one cycle, so catch them at every falling edge
  always @(negedge i_core_clk) begin
    if (o_read_bus_one_vld) r1 = o_read_bus_one;
    if (o_read_bus_two_vld) r2 = o_read_bus_two;
    if (o_coef_vld) rc = o_coef_read_bus;
    if (o_fetch_vld) rf = o_fetch_bus;
    if (o_dma_vld) rdm = o_dma_rdata;
    if (o_io_wr) iow = {o_io_wr_addr, o_io_wdata};
    seen = seen | {o_wr_pend, o_fetch_stall, o_dma_stall};
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // each group is held until its stall is low at the taking edge
  task automatic go;
    logic d, f, m;
    {r1, r2, rc, rdm, rf, iow} = 'x;
    seen = 3'h0;
    repeat (12) begin
      d = !o_data_stall;
      f = !o_fetch_stall;
      m = !o_dma_stall;
      @(negedge i_core_clk);
      if (d) {i_rd1_req, i_rd1_io, i_rd_long, i_rd2_req, i_coef_req, i_wr1_req, i_wr1_io, i_wr_long, i_wr2_req} = 9'h000;
      if (f) i_fetch_req = 1'b0;
      if (m) i_dma_req = 1'b0;
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] b, input logic two, input logic lng);
    i_rd1_req = 1'b1;
    i_rd1_addr = a;
    i_rd2_req = two;
    i_rd2_addr = b;
    i_rd_long = lng;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [15:0] b, input logic [15:0] e,
                    input logic two, input logic lng);
    i_wr1_req = 1'b1;
    i_wr1_addr = a;
    i_wr1_data = d;
    i_wr2_req = two;
    i_wr2_addr = b;
    i_wr2_data = e;
    i_wr_long = lng;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // dual write and dual read in the dual block, then a single pair
  task automatic t_dual;
    wr(16'h0010, 16'h1234, 16'h0011, 16'h5678, 1'b1, 1'b0);
    go();
    wr(16'h0012, 16'h9ABC, 16'h0000, 16'h0000, 1'b0, 1'b0);
    go();
    rd(16'h0010, 16'h0011, 1'b1, 1'b0);
    go();
    chk("read bus one", 32'h1234, r1);
    chk("read bus two", 32'h5678, r2);
    rd(16'h0012, 16'h0000, 1'b0, 1'b0);
    go();
    chk("single read", 32'h9ABC, r1);
  endtask
  // long write, long read and a fetch of the same pair
  task automatic t_long;
    wr(16'h0020, 16'hAAAA, 16'h0000, 16'hBBBB, 1'b0, 1'b1);
    go();
    rd(16'h0020, 16'h0000, 1'b0, 1'b1);
    go();
    chk("long even", 32'hAAAA, r1);
    chk("long odd", 32'hBBBB, r2);
    i_fetch_req = 1'b1;
    i_fetch_addr = 16'h0021;
    go();
    chk("fetch pair", 32'hAAAABBBB, rf);
  endtask
  // io space only through bus one, both ways
  task automatic t_io;
    i_rd1_io = 1'b1;
    rd(16'h0040, 16'h0000, 1'b0, 1'b0);
    go();
    chk("io read", {16'h0000, 16'h0040 ^ IO_KEY}, r1);
    i_wr1_io = 1'b1;
    wr(16'h0041, 16'hBEEF, 16'h0000, 16'h0000, 1'b0, 1'b0);
    go();
    chk("io write", 32'h0041BEEF, iow);
  endtask
  // two reads on the single block must be split over cycles
  task automatic t_blk;
    wr(16'h0106, 16'h0F0F, 16'h0000, 16'hF0F0, 1'b0, 1'b1);
    go();
    rd(16'h0106, 16'h0107, 1'b1, 1'b0);
    go();
    chk("single block one", 32'h0F0F, r1);
    chk("single block two", 32'hF0F0, r2);
  endtask
  // coefficient beside a dual read, same block and other block
  task automatic t_coef;
    rd(16'h0010, 16'h0011, 1'b1, 1'b0);
    i_coef_req = 1'b1;
    i_coef_addr = 16'h0012;
    go();
    chk("coef same block", 32'h9ABC, rc);
    chk("coef partner read", 32'h5678, r2);
    rd(16'h0010, 16'h0011, 1'b1, 1'b0);
    i_coef_req = 1'b1;
    i_coef_addr = 16'h0106;
    go();
    chk("coef other block", 32'h0F0F, rc);
  endtask
  // write losing its half to a dual read, same location read back
  task automatic t_pend;
    rd(16'h0013, 16'h0011, 1'b1, 1'b0);
    wr(16'h0013, 16'h4321, 16'h0000, 16'h0000, 1'b0, 1'b0);
    go();
    chk("forwarded read", 32'h4321, r1);
    chk("write held back", 32'h1, {31'h0, seen[2]});
    rd(16'h0013, 16'h0000, 1'b0, 1'b0);
    go();
    chk("held write landed", 32'h4321, r1);
  endtask
  // data, fetch and dma all on the single block at once
  task automatic t_prio;
    rd(16'h0107, 16'h0000, 1'b0, 1'b0);
    i_fetch_req = 1'b1;
    i_fetch_addr = 16'h0106;
    i_dma_req = 1'b1;
    i_dma_addr = 16'h0106;
    go();
    chk("data read", 32'hF0F0, r1);
    chk("fetch after data", 32'h0F0FF0F0, rf);
    chk("dma last", 32'h0F0F, rdm);
    chk("lower ones stalled", 32'h3, {30'h0, seen[1:0]});
    // dma write into the dual block, then read it back over dma
    i_dma_we = 1'b1;
    i_dma_wdata = 16'h2468;
    i_dma_addr = 16'h0015;
    i_dma_req = 1'b1;
    go();
    i_dma_we = 1'b0;
    i_dma_req = 1'b1;
    go();
    chk("dma write back", 32'h2468, rdm);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_rd1_addr, i_rd2_addr, i_coef_addr, i_wr1_addr, i_wr1_data, i_wr2_addr, i_wr2_data} = 112'h0;
    {i_fetch_addr, i_dma_addr, i_dma_wdata} = 48'h0;
    {i_rd1_req, i_rd1_io, i_rd_long, i_rd2_req, i_coef_req, i_wr1_req, i_wr1_io, i_wr_long} = 8'h00;
    {i_wr2_req, i_fetch_req, i_dma_req, i_dma_we} = 4'h0;
    seen = 3'h0;
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_dual();
    t_long();
    t_io();
    t_blk();
    t_coef();
    t_pend();
    t_prio();
    complete_run();
  end
endmodule
`default_nettype wire
